/* common/sequencer_pkg.sv */
// Purpose: shared constants and types of the multiphase start-up sequencer
// Assumes: 250 MHz core clock
// Notes: times are kept in their own unit, cycle counts derived from them
package sequencer_pkg;

    // =========================================================
    // clock and timing
    localparam int unsigned CLOCK_MHZ = 250;
    localparam int unsigned CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
    // power-good masking after the final ramp, in ns
    localparam int unsigned GOOD_MASK_NS = 100000;
    localparam int unsigned GOOD_MASK_CYCLES = GOOD_MASK_NS / CLOCK_PERIOD_NS;
    // master oscillator period in core clocks
    localparam int unsigned MASTER_DIV_DEFAULT = 50;

    // =========================================================
    // phase layout
    localparam int unsigned PHASE_MAX = 5;
    localparam int unsigned OPT_FIRST = 2;
    localparam int unsigned DETECT_TICKS = 5;
    localparam logic [2:0] PHASES_DEFAULT = 3'h5;
    localparam logic [4:0] PHASE_OUT_RESET = 5'h00;

    // =========================================================
    // types
    typedef enum {
        ST_OFF,
        ST_FIRST_DELAY,
        ST_DETECT,
        ST_BOOT_RAMP,
        ST_BOOT_HOLD,
        ST_FINAL_RAMP,
        ST_GOOD_MASK,
        ST_GOOD_BLANK,
        ST_RUN
    } seq_state_t;

    // completion strobes from the analog timer, soft-start and window comparators
    typedef struct packed {
        logic delay_done;
        logic ss_near_boot;
        logic ss_final_done;
        logic vout_in_range;
    } analog_status_t;

    // controls toward the analog timer and soft-start amplifier
    typedef struct packed {
        logic delay_charge;
        logic ss_release;
        logic ss_to_code;
        logic osc_enable;
    } analog_ctrl_t;

endpackage

/* sim/multiphase_startup_sequencer_tb_top.sv */
// Purpose: self-checking bench of the start-up sequencer
// Assumes: short divider and mask counts through parameters
// Notes: expectations come from the tie table, never from the design
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module multiphase_startup_sequencer_tb_top;
    localparam int DIV = 4;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic enable_pin = 1'b0;
    logic supply_low_lockout = 1'b1;
    logic [2:0] tie_cfg = 3'h0;
    logic [7:0] delay_len = 8'h03;
    logic [7:0] duty = 8'h01;
    int n_errors = 0;
    int check_count = 0;
    sequencer_pkg::analog_status_t status;
    sequencer_pkg::analog_ctrl_t ctrl;
    logic [2:0] opt_tied_high, weak_sink_en, phase_count;
    logic [4:0] phase_trip, phase_out, phase_oe;
    logic power_good_out, driver_off_n;
    logic [2:0] ties [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
    always #2 clock = ~clock;
    multiphase_startup_sequencer #(.MASTER_DIV(DIV), .GOOD_MASK_LEN(4)) dut (
        .clock(clock), .srst(srst), .enable_pin(enable_pin),
        .supply_low_lockout(supply_low_lockout), .status(status),
        .opt_tied_high(opt_tied_high), .phase_trip(phase_trip), .phase_out(phase_out),
        .phase_oe(phase_oe), .weak_sink_en(weak_sink_en), .ctrl(ctrl),
        .phase_count(phase_count), .power_good_out(power_good_out),
        .driver_off_n(driver_off_n)
    );
    startup_partner far (
        .clock(clock), .ctrl(ctrl), .phase_out(phase_out), .tie_cfg(tie_cfg),
        .delay_len(delay_len), .duty(duty), .status(status),
        .opt_tied_high(opt_tied_high), .phase_trip(phase_trip)
    );
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // =========================================================
    // idle outputs after reset or shutdown
    task automatic check_off(string nm);
        `CHK({nm, " phase_out"}, 5'h00, phase_out)
        `CHK({nm, " phase_oe"}, 5'h03, phase_oe)
        `CHK({nm, " weak_sink_en"}, 3'h7, weak_sink_en)
        `CHK({nm, " ctrl"}, 4'h0, ctrl)
        `CHK({nm, " phase_count"}, 3'h5, phase_count)
        `CHK({nm, " power_good_out"}, 1'b0, power_good_out)
        `CHK({nm, " driver_off_n"}, 1'b0, driver_off_n)
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        conclude();
    end
    initial
    begin
        int exp_n;
        int cyc;
        int ov;
        int w;
        logic [4:0] prev;
        int q [$];
        void'($urandom(22785));
        repeat (6) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        check_off("reset");
        $display("test reset done");
        for (int k = 0; k < 4; k++)
        begin
            exp_n = 5 - $countones(ties[k]);
            tie_cfg = ties[k];
            delay_len = 8'(2 + $urandom % 6);
            duty = 8'(1 + $urandom % (DIV * exp_n - 1));
            enable_pin = 1'b1;
            supply_low_lockout = 1'b0;
            for (w = 0; w < 3000 && power_good_out !== 1'b1; w++)
                @(negedge clock);
            `CHK("power_good_out", 1'b1, power_good_out)
            `CHK("driver_off_n", 1'b1, driver_off_n)
            `CHK("phase_count", 3'(exp_n), phase_count)
            `CHK("phase_oe", {~ties[k], 2'h3}, phase_oe)
            `CHK("weak_sink_en", 3'h0, weak_sink_en)
            q.delete();
            ov = 0;
            prev = phase_out;
            for (cyc = 0; cyc < 5 * DIV * exp_n; cyc++)
            begin
                @(negedge clock);
                if (phase_out[0] && !prev[0])
                    q.push_back(cyc);
                if ($countones(phase_out) > 1)
                    ov++;
                prev = phase_out;
            end
            for (int j = 1; j < q.size(); j++)
                `CHK("phase one period", DIV * exp_n, q[j] - q[j - 1])
            `CHK("phase one rises", 1'b1, q.size() >= 4)
            `CHK("overlap", duty > DIV, ov > 0)
            // lockout and enable take turns at shutting down
            if (k % 2 == 0)
                enable_pin = 1'b0;
            else
                supply_low_lockout = 1'b1;
            repeat (8) @(negedge clock);
            check_off("shutdown");
            $display("test tie %0h done", ties[k]);
        end
        supply_low_lockout = 1'b0;
        for (w = 0; w < 500 && ctrl.ss_release !== 1'b1; w++)
            @(negedge clock);
        `CHK("ramp reached", 1'b1, ctrl.ss_release)
        enable_pin = 1'b0;
        repeat (8) @(negedge clock);
        check_off("abort");
        $display("test abort done");
        conclude();
    end
endmodule

/* sim/seq_asserts.sv */
// Purpose: port checker for the start-up sequencer
// Assumes: done strobes from the far side are single pulses
// Notes: bound to every sequencer instance below
`timescale 1ns/10ps
module seq_asserts #(
    parameter int unsigned MASTER_DIV = 50,
    parameter int unsigned GOOD_MASK_LEN = 4
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic enable_pin,
    input wire logic supply_low_lockout,
    input wire sequencer_pkg::analog_status_t status,
    input wire logic [4:0] phase_trip,
    input wire logic [4:0] phase_out,
    input wire logic [4:0] phase_oe,
    input wire logic [2:0] weak_sink_en,
    input wire sequencer_pkg::analog_ctrl_t ctrl,
    input wire logic [2:0] phase_count,
    input wire logic power_good_out,
    input wire logic driver_off_n
);
    // detection start phase vs divider is unknown, so one tick of slack
    localparam int DET_LO = 4 * MASTER_DIV;
    localparam int DET_HI = 5 * MASTER_DIV + 4;
    localparam int MASK_LO = GOOD_MASK_LEN;
    localparam int MASK_HI = GOOD_MASK_LEN + 4;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // =========================================================
    // sequence steps
    sequence timer_first_s;
        !ctrl.delay_charge && !ctrl.osc_enable ##1 ctrl.delay_charge && !ctrl.osc_enable;
    endsequence
    sequence hold_done_s;
        ctrl.ss_release && ctrl.delay_charge && !ctrl.ss_to_code && status.delay_done;
    endsequence
    sequence final_done_s;
        ctrl.ss_to_code && !ctrl.delay_charge && status.ss_final_done;
    endsequence
    a_off_quiet: assert property ((!enable_pin || supply_low_lockout) [*6] |->
        !driver_off_n && ctrl == 4'h0 && phase_out == 5'h00 && !power_good_out)
        else $error("outputs live while disabled");
    a_first_delay: assert property ($rose(driver_off_n) |-> timer_first_s)
        else $error("start without first delay");
    a_osc_start: assert property (ctrl.delay_charge && !ctrl.osc_enable && status.delay_done
        |-> ##2 ctrl.osc_enable && !ctrl.delay_charge) else $error("oscillator late");
    a_detect_len: assert property ($rose(ctrl.osc_enable) |->
        ##[DET_LO:DET_HI] $rose(ctrl.ss_release)) else $error("detection length wrong");
    a_detect_blank: assert property (ctrl.osc_enable && !ctrl.ss_release && !ctrl.ss_to_code
        |-> phase_out == 5'h00 && phase_oe == 5'h03 && weak_sink_en == 3'h7)
        else $error("outputs not blanked in detection");
    a_after_detect: assert property (ctrl.ss_release |-> weak_sink_en == 3'h0 &&
        (phase_oe >> phase_count) == 5'h00 && $countones(phase_oe) == phase_count)
        else $error("drive enables disagree with count");
    a_boot_hold: assert property (ctrl.ss_release && !ctrl.delay_charge && !ctrl.ss_to_code
        && status.ss_near_boot |-> ##[1:3] ctrl.delay_charge) else $error("boot hold missing");
    a_final_ramp: assert property (hold_done_s |-> ##[1:3] ctrl.ss_to_code)
        else $error("final ramp missing");
    a_good_mask: assert property (final_done_s |-> ##[MASK_LO:MASK_HI] $rose(ctrl.delay_charge))
        else $error("mask interval wrong");
    a_good_blank: assert property (ctrl.delay_charge && ctrl.ss_to_code |-> !power_good_out)
        else $error("power good not blanked");
    a_trip_wins: assert property (|phase_trip |=> (phase_out & $past(phase_trip)) == 5'h00)
        else $error("tripped phase stayed high");
endmodule
bind multiphase_startup_sequencer seq_asserts #(
    .MASTER_DIV(MASTER_DIV), .GOOD_MASK_LEN(GOOD_MASK_LEN)
) u_seq_chk (
    .clock(clock), .srst(srst), .enable_pin(enable_pin),
    .supply_low_lockout(supply_low_lockout), .status(status), .phase_trip(phase_trip),
    .phase_out(phase_out), .phase_oe(phase_oe), .weak_sink_en(weak_sink_en), .ctrl(ctrl),
    .phase_count(phase_count), .power_good_out(power_good_out), .driver_off_n(driver_off_n)
);

/* sim/startup_partner.sv */
// Purpose: far side: delay timer, soft-start, pin comparators, drivers
// Assumes: lengths set by the bench, at least one cycle
// Notes: every done strobe is one cycle wide
`timescale 1ns/10ps
module startup_partner (
    input wire logic clock,
    input wire sequencer_pkg::analog_ctrl_t ctrl,
    input wire logic [4:0] phase_out,
    input wire logic [2:0] tie_cfg,
    input wire logic [7:0] delay_len,
    input wire logic [7:0] duty,
    output sequencer_pkg::analog_status_t status,
    output logic [2:0] opt_tied_high,
    output logic [4:0] phase_trip
);
    int dly_q;
    int boot_q;
    int fin_q;
    int on_q [5];
    // =========================================================
    // capacitors discharge when released
    always_ff @(posedge clock)
    begin
        dly_q <= ctrl.delay_charge ? dly_q + 1 : 0;
        boot_q <= (ctrl.ss_release && !ctrl.ss_to_code) ? boot_q + 1 : 0;
        fin_q <= ctrl.ss_to_code ? fin_q + 1 : 0;
        for (int i = 0; i < 5; i++)
            on_q[i] <= phase_out[i] ? on_q[i] + 1 : 0;
    end
    // near boot level ends the ramp
    assign status.delay_done = dly_q == delay_len;
    assign status.ss_near_boot = boot_q == delay_len + 1;
    assign status.ss_final_done = fin_q == delay_len + 2;
    assign status.vout_in_range = ctrl.ss_to_code;
    // pins tied to supply read above threshold
    assign opt_tied_high = tie_cfg;
    always_comb
    begin
        for (int i = 0; i < 5; i++)
            phase_trip[i] = phase_out[i] && on_q[i] + 1 >= duty;
    end
endmodule

/* src/multiphase_startup_sequencer.sv */
// Purpose: start-up sequencing, phase-count detection and phase gating
// Assumes: analog completion and comparator results arrive synchronous to clock
// Notes: enable and lockout come from pins and are double-flopped
//
// Behaviour
// - after enable and lockout clear, run first_delay, then start the oscillator
// - first five oscillator cycles blank phase outputs, used only for detection
// - after detection run boot_ramp to the 1.1 V boot level and wait
// - hold the boot level for boot_hold while the voltage code settles
// - after boot_hold ramp from boot level to the voltage-code level
// - after final_ramp and masking interval run good_blank blanking power good
// - five phases by default; tied optional outputs reduce to four, three, two
// - optional output above 3.15 V comparator counts tied high, else in use
// - phase outputs one and two held low throughout detection
// - optional output in use drops its weak sink and drives normally
// - tied optional output goes high impedance; excluded from rotation only when ties run down from phase five
// - each active phase controlled independently; overlap and near 100% allowed
// - per-phase rate equals master clock divided by active phase count
// - enable low or lockout resets delay timer and soft-start state
// - boot_hold starts once soft-start is within 100 mV of boot level
// - enable low disables all phase outputs and drives power good low
// - driver_off low whenever enable low or supply below lockout
`timescale 1ns/10ps
module multiphase_startup_sequencer #(
    parameter int unsigned MASTER_DIV = sequencer_pkg::MASTER_DIV_DEFAULT,
    parameter int unsigned GOOD_MASK_LEN = sequencer_pkg::GOOD_MASK_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic enable_pin,
    input wire logic supply_low_lockout,
    input wire sequencer_pkg::analog_status_t status,
    input wire logic [2:0] opt_tied_high,
    input wire logic [4:0] phase_trip,
    output logic [4:0] phase_out,
    output logic [4:0] phase_oe,
    output logic [2:0] weak_sink_en,
    output sequencer_pkg::analog_ctrl_t ctrl,
    output logic [2:0] phase_count,
    output logic power_good_out,
    output logic driver_off_n
);

    if (MASTER_DIV < 2 || GOOD_MASK_LEN < 1)
    begin
        $error("multiphase_startup_sequencer: bad divider or mask length");
    end

    // =========================================================
    // helpers

    // tied pattern to phase count, checked from the widest tie down
    function automatic logic [2:0] count_from_ties(input logic [2:0] tied);
        case (tied)
            3'h7: return 3'h2;
            3'h6: return 3'h3;
            3'h4, 3'h5: return 3'h4;
            default: return sequencer_pkg::PHASES_DEFAULT;
        endcase
    endfunction

    // phases below the count rotate; the rest are out
    function automatic logic [4:0] mask_from_count(input logic [2:0] n);
        return 5'((6'h01 << n) - 6'h01);
    endfunction

    // =========================================================
    // pin synchronisers
    logic en_meta_q;
    logic en_sync_q;
    logic low_meta_q;
    logic low_sync_q;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
            low_meta_q <= 1'b1;
            low_sync_q <= 1'b1;
        end
        else
        begin
            en_meta_q <= enable_pin;
            en_sync_q <= en_meta_q;
            low_meta_q <= supply_low_lockout;
            low_sync_q <= low_meta_q;
        end
    end

    logic run_ok;
    assign run_ok = en_sync_q && !low_sync_q;

    // =========================================================
    // sequencer state
    sequencer_pkg::seq_state_t state_q;
    logic master_tick_q;
    logic [2:0] detect_cnt_q;
    logic [$clog2(GOOD_MASK_LEN + 1)-1:0] mask_cnt_q;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_q <= sequencer_pkg::ST_OFF;
        end
        else if (!run_ok)
        begin
            state_q <= sequencer_pkg::ST_OFF;
        end
        else
        begin
            case (state_q)
                sequencer_pkg::ST_OFF:
                begin
                    state_q <= sequencer_pkg::ST_FIRST_DELAY;
                end
                sequencer_pkg::ST_FIRST_DELAY:
                begin
                    if (status.delay_done)
                    begin
                        state_q <= sequencer_pkg::ST_DETECT;
                    end
                end
                sequencer_pkg::ST_DETECT:
                begin
                    if (master_tick_q && detect_cnt_q == 3'(sequencer_pkg::DETECT_TICKS - 1))
                    begin
                        state_q <= sequencer_pkg::ST_BOOT_RAMP;
                    end
                end
                sequencer_pkg::ST_BOOT_RAMP:
                begin
                    if (status.ss_near_boot)
                    begin
                        state_q <= sequencer_pkg::ST_BOOT_HOLD;
                    end
                end
                sequencer_pkg::ST_BOOT_HOLD:
                begin
                    if (status.delay_done)
                    begin
                        state_q <= sequencer_pkg::ST_FINAL_RAMP;
                    end
                end
                sequencer_pkg::ST_FINAL_RAMP:
                begin
                    if (status.ss_final_done)
                    begin
                        state_q <= sequencer_pkg::ST_GOOD_MASK;
                    end
                end
                sequencer_pkg::ST_GOOD_MASK:
                begin
                    if (mask_cnt_q == ($bits(mask_cnt_q))'(GOOD_MASK_LEN - 1))
                    begin
                        state_q <= sequencer_pkg::ST_GOOD_BLANK;
                    end
                end
                sequencer_pkg::ST_GOOD_BLANK:
                begin
                    if (status.delay_done)
                    begin
                        state_q <= sequencer_pkg::ST_RUN;
                    end
                end
                sequencer_pkg::ST_RUN:
                begin
                    state_q <= sequencer_pkg::ST_RUN;
                end
                default:
                begin
                    state_q <= sequencer_pkg::ST_OFF;
                end
            endcase
        end
    end

    // =========================================================
    // masking counter
    always_ff @(posedge clock)
    begin
        if (srst || state_q != sequencer_pkg::ST_GOOD_MASK)
        begin
            mask_cnt_q <= '0;
        end
        else
        begin
            mask_cnt_q <= mask_cnt_q + 1'b1;
        end
    end

    // =========================================================
    // master oscillator as a tick enable
    logic osc_on;
    logic [$clog2(MASTER_DIV)-1:0] div_q;
    assign osc_on = state_q != sequencer_pkg::ST_OFF && state_q != sequencer_pkg::ST_FIRST_DELAY;

    always_ff @(posedge clock)
    begin
        if (srst || !osc_on || !run_ok)
        begin
            div_q <= '0;
            master_tick_q <= 1'b0;
        end
        else
        begin
            master_tick_q <= div_q == ($bits(div_q))'(MASTER_DIV - 1);
            div_q <= (div_q == ($bits(div_q))'(MASTER_DIV - 1)) ? '0 : div_q + 1'b1;
        end
    end

    // =========================================================
    // phase-count detection
    logic [2:0] tied_q;

    always_ff @(posedge clock)
    begin
        if (srst || state_q == sequencer_pkg::ST_OFF)
        begin
            detect_cnt_q <= 3'h0;
            tied_q <= 3'h0;
            phase_count <= sequencer_pkg::PHASES_DEFAULT;
        end
        else if (state_q == sequencer_pkg::ST_DETECT && master_tick_q)
        begin
            detect_cnt_q <= detect_cnt_q + 3'h1;
            if (detect_cnt_q == 3'(sequencer_pkg::DETECT_TICKS - 1))
            begin
                // comparator result taken as tied high
                tied_q <= opt_tied_high;
                phase_count <= count_from_ties(opt_tied_high);
            end
        end
    end

    // =========================================================
    // phase rotation and outputs
    logic switching;
    logic [2:0] slot_q;
    logic [4:0] active;
    assign switching = run_ok && state_q != sequencer_pkg::ST_OFF
        && state_q != sequencer_pkg::ST_FIRST_DELAY && state_q != sequencer_pkg::ST_DETECT;
    assign active = mask_from_count(phase_count);

    // slot wraps at phase count, one start per phase each round
    always_ff @(posedge clock)
    begin
        if (srst || !switching)
        begin
            slot_q <= 3'h0;
        end
        else if (master_tick_q)
        begin
            slot_q <= (slot_q == phase_count - 3'h1) ? 3'h0 : slot_q + 3'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || !switching)
        begin
            phase_out <= sequencer_pkg::PHASE_OUT_RESET;
        end
        else
        begin
            for (int i = 0; i < sequencer_pkg::PHASE_MAX; i++)
            begin
                // independent set and trip per phase
                if (!active[i] || phase_trip[i])
                begin
                    phase_out[i] <= 1'b0;
                end
                else if (master_tick_q && slot_q == 3'(i))
                begin
                    phase_out[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || !switching)
        begin
            // phases one and two driven low; optional ones sensed
            phase_oe <= 5'h03;
            weak_sink_en <= 3'h7;
        end
        else
        begin
            phase_oe[1:0] <= 2'h3;
            // used outputs drive, tied ones float
            phase_oe[4:sequencer_pkg::OPT_FIRST] <= ~tied_q;
            weak_sink_en <= 3'h0;
        end
    end

    // =========================================================
    // analog controls, power good, driver off
    always_ff @(posedge clock)
    begin
        if (srst || !run_ok)
        begin
            ctrl <= '0;
            // outputs off with enable low or lockout
            power_good_out <= 1'b0;
            driver_off_n <= 1'b0;
        end
        else
        begin
            // delay timer charges in its three phases
            ctrl.delay_charge <= state_q == sequencer_pkg::ST_FIRST_DELAY
                || state_q == sequencer_pkg::ST_BOOT_HOLD
                || state_q == sequencer_pkg::ST_GOOD_BLANK;
            ctrl.ss_release <= switching;
            ctrl.ss_to_code <= switching && state_q != sequencer_pkg::ST_BOOT_RAMP
                && state_q != sequencer_pkg::ST_BOOT_HOLD;
            ctrl.osc_enable <= osc_on;
            // power good blanked until sequence done
            power_good_out <= state_q == sequencer_pkg::ST_RUN && status.vout_in_range;
            driver_off_n <= 1'b1;
        end
    end

endmodule
